// [rtl/lce_ladder_contact_evaluator.sv]
// Contact load and parallel-contact evaluator for the ladder scan
// Function
// RULE_01 - A load-contact opens a new rung whose result is the referenced bit.
// RULE_02 - An inverted load-contact opens a new rung whose result is the bit complemented.
// RULE_03 - A parallel-contact ORs the referenced bit, uninverted, into the result.
// RULE_04 - A timer-load opens a new rung with timer current value >= preset.
// RULE_05 - An inverted timer-load opens a new rung with timer current value < preset.
// RULE_06 - A counter-load opens a new rung with counter current value >= preset.
// RULE_07 - An inverted counter-load opens a new rung with counter current value < preset.
// RULE_08 - Operands are octal bit addresses; out-of-range addresses are ignored and flagged.
`timescale 1ns/100ps
module lce_ladder_contact_evaluator
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Instruction stream
    input wire logic instr_valid,
    input wire logic [3:0] instr_op,
    input wire logic [9:0] instr_addr,
    // Bit memory lookup (combinational, same cycle)
    output logic [9:0] bit_addr,
    input wire logic bit_value,
    // Timer and counter value lookup (combinational, same cycle)
    output logic [5:0] tc_index,
    input wire logic [15:0] timer_current,
    input wire logic [15:0] timer_preset,
    input wire logic [15:0] counter_current,
    input wire logic [15:0] counter_preset,
    // Results
    output logic rung_result,
    output logic result_valid,
    output logic addr_error
);
    logic rung_result_reg;
    logic rung_result_next;
    logic result_valid_reg;
    logic addr_error_reg;
    logic addr_error_next;

    wire lce_pkg::lce_op_t op = lce_pkg::lce_op_t'(instr_op);
    wire in_io = (instr_addr <= lce_pkg::LCE_IO_HI)
        || (instr_addr >= lce_pkg::LCE_IO2_LO && instr_addr <= lce_pkg::LCE_IO2_HI);
    wire in_cr = (instr_addr >= lce_pkg::LCE_CR_LO && instr_addr <= lce_pkg::LCE_CR_HI)
        || (instr_addr >= lce_pkg::LCE_CR2_LO && instr_addr <= lce_pkg::LCE_CR2_HI);
    wire in_sp = (instr_addr >= lce_pkg::LCE_SP_LO && instr_addr <= lce_pkg::LCE_SP_HI)
        || (instr_addr >= lce_pkg::LCE_SP2_LO && instr_addr <= lce_pkg::LCE_SP2_HI)
        || (instr_addr >= lce_pkg::LCE_SP3_LO && instr_addr <= lce_pkg::LCE_SP3_HI);
    wire in_sr = instr_addr >= lce_pkg::LCE_SR_LO && instr_addr <= lce_pkg::LCE_SR_HI;
    wire bit_ok = in_io || in_cr || in_sp || in_sr; // [RULE_08]
    wire tc_ok = instr_addr >= lce_pkg::LCE_TC_LO && instr_addr <= lce_pkg::LCE_TC_HI; // [RULE_08]
    // Unsigned compares; a zero preset reads as done at once
    wire timer_done = timer_current >= timer_preset;
    wire counter_done = counter_current >= counter_preset;
    // Range base is a multiple of 64, so the low six bits index directly
    wire [9:0] tc_offset = instr_addr - lce_pkg::LCE_TC_LO;
    wire is_bit_op = op == lce_pkg::LCE_OP_LOAD_CONTACT
        || op == lce_pkg::LCE_OP_LOAD_INVERTED_CONTACT || op == lce_pkg::LCE_OP_OR_CONTACT;
    wire is_tc_op = op == lce_pkg::LCE_OP_LOAD_TIMER_STATUS
        || op == lce_pkg::LCE_OP_LOAD_INVERTED_TIMER_STATUS
        || op == lce_pkg::LCE_OP_LOAD_COUNTER_STATUS
        || op == lce_pkg::LCE_OP_LOAD_INVERTED_COUNTER_STATUS;
    // Unknown opcodes and bad operands leave the result untouched
    wire accept = instr_valid && ((is_bit_op && bit_ok) || (is_tc_op && tc_ok)); // [RULE_08]

    assign bit_addr = instr_addr;
    assign tc_index = tc_offset[5:0] & lce_pkg::LCE_TC_IDX_W6;

    always_comb
    begin
        rung_result_next = rung_result_reg;
        case (op)
            lce_pkg::LCE_OP_LOAD_CONTACT: rung_result_next = bit_value; // [RULE_01]
            lce_pkg::LCE_OP_LOAD_INVERTED_CONTACT: rung_result_next = ~bit_value; // [RULE_02]
            lce_pkg::LCE_OP_OR_CONTACT: rung_result_next = rung_result_reg | bit_value; // [RULE_03]
            lce_pkg::LCE_OP_LOAD_TIMER_STATUS: rung_result_next = timer_done; // [RULE_04]
            lce_pkg::LCE_OP_LOAD_INVERTED_TIMER_STATUS: rung_result_next = ~timer_done; // [RULE_05]
            lce_pkg::LCE_OP_LOAD_COUNTER_STATUS: rung_result_next = counter_done; // [RULE_06]
            lce_pkg::LCE_OP_LOAD_INVERTED_COUNTER_STATUS:
                rung_result_next = ~counter_done; // [RULE_07]
            default: rung_result_next = rung_result_reg;
        endcase
        addr_error_next = instr_valid && !accept; // [RULE_08]
    end

    // Result held across idle or refused cycles so a rung can resume
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            rung_result_reg <= lce_pkg::LCE_RESULT_RST;
            result_valid_reg <= 1'b0;
            addr_error_reg <= 1'b0;
        end
        else
        begin
            if (accept)
                rung_result_reg <= rung_result_next;
            result_valid_reg <= accept;
            addr_error_reg <= addr_error_next;
        end
    end

    assign rung_result = rung_result_reg;
    assign result_valid = result_valid_reg;
    assign addr_error = addr_error_reg;

    // Checks
    sequence s_load_bit;
        instr_valid && op == lce_pkg::LCE_OP_LOAD_CONTACT && bit_ok;
    endsequence
    AST_LOAD: assert property (@(posedge sys_clk) disable iff (reset) // [RULE_01]
        s_load_bit |=> rung_result == $past(bit_value) && result_valid)
        else $error("load contact result wrong");
    AST_LOAD_INV: assert property (@(posedge sys_clk) disable iff (reset) // [RULE_02]
        instr_valid && op == lce_pkg::LCE_OP_LOAD_INVERTED_CONTACT && bit_ok
        |=> rung_result == !$past(bit_value))
        else $error("inverted load result wrong");
    AST_OR: assert property (@(posedge sys_clk) disable iff (reset) // [RULE_03]
        instr_valid && op == lce_pkg::LCE_OP_OR_CONTACT && bit_ok
        |=> rung_result == ($past(rung_result) | $past(bit_value)))
        else $error("or contact result wrong");
    AST_TMR: assert property (@(posedge sys_clk) disable iff (reset) // [RULE_04]
        instr_valid && op == lce_pkg::LCE_OP_LOAD_TIMER_STATUS && tc_ok
        |=> rung_result == ($past(timer_current) >= $past(timer_preset)))
        else $error("timer status wrong");
    AST_TMR_INV: assert property (@(posedge sys_clk) disable iff (reset) // [RULE_05]
        instr_valid && op == lce_pkg::LCE_OP_LOAD_INVERTED_TIMER_STATUS && tc_ok
        |=> rung_result == ($past(timer_current) < $past(timer_preset)))
        else $error("inverted timer status wrong");
    AST_CNT: assert property (@(posedge sys_clk) disable iff (reset) // [RULE_06]
        instr_valid && op == lce_pkg::LCE_OP_LOAD_COUNTER_STATUS && tc_ok
        |=> rung_result == ($past(counter_current) >= $past(counter_preset)))
        else $error("counter status wrong");
    AST_CNT_INV: assert property (@(posedge sys_clk) disable iff (reset) // [RULE_07]
        instr_valid && op == lce_pkg::LCE_OP_LOAD_INVERTED_COUNTER_STATUS && tc_ok
        |=> rung_result == ($past(counter_current) < $past(counter_preset)))
        else $error("inverted counter status wrong");
    AST_BAD_ADDR: assert property (@(posedge sys_clk) disable iff (reset) // [RULE_08]
        instr_valid && is_bit_op && !bit_ok
        |=> addr_error && !result_valid && $stable(rung_result))
        else $error("bad address not rejected");

    // Refusal and handshake checks
    sequence s_bad_tc;
        instr_valid && is_tc_op && !tc_ok;
    endsequence
    sequence s_bad_op;
        instr_valid && !is_bit_op && !is_tc_op;
    endsequence
    sequence s_idle;
        !instr_valid;
    endsequence
    AST_TC_BAD_ADDR: assert property (@(posedge sys_clk) disable iff (reset) // [RULE_08]
        s_bad_tc |=> addr_error && !result_valid && $stable(rung_result))
        else $error("bad timer or counter address not rejected");
    AST_BAD_OP: assert property (@(posedge sys_clk) disable iff (reset) // [RULE_08]
        s_bad_op |=> addr_error && !result_valid && $stable(rung_result))
        else $error("unknown opcode not rejected");
    // Addresses past the last special relay exist in no range
    AST_HIGH_ADDR: assert property (@(posedge sys_clk) disable iff (reset) // [RULE_08]
        instr_valid && instr_addr > lce_pkg::LCE_SP3_HI
        |=> addr_error && !result_valid)
        else $error("address above all ranges not rejected");
    // The timer and counter block is not bit memory
    AST_TC_GAP: assert property (@(posedge sys_clk) disable iff (reset) // [RULE_08]
        instr_valid && is_bit_op && instr_addr >= lce_pkg::LCE_TC_LO
        && instr_addr <= lce_pkg::LCE_TC_HI |=> addr_error)
        else $error("bit contact in timer range not rejected");
    AST_ACCEPT_PULSE: assert property (@(posedge sys_clk) disable iff (reset) // [RULE_08]
        accept |=> result_valid && !addr_error)
        else $error("accepted instruction not flagged");
    AST_IDLE: assert property (@(posedge sys_clk) disable iff (reset) // [RULE_08]
        s_idle |=> !result_valid && !addr_error && $stable(rung_result))
        else $error("idle cycle changed the result");
    AST_ONE_ANSWER: assert property (@(posedge sys_clk) disable iff (reset) // [RULE_08]
        instr_valid |=> result_valid || addr_error)
        else $error("instruction got no answer");

    // Lookup check: the operand indexes the unit in the cycle it is taken
    AST_TC_INDEX: assert property (@(posedge sys_clk) disable iff (reset) // [RULE_08]
        tc_ok |-> tc_index == instr_addr[5:0])
        else $error("timer or counter index wrong");

    // Chained checks: a load followed at once by a parallel contact
    sequence s_or_bit;
        instr_valid && op == lce_pkg::LCE_OP_OR_CONTACT && bit_ok;
    endsequence
    sequence s_load_inv_bit;
        instr_valid && op == lce_pkg::LCE_OP_LOAD_INVERTED_CONTACT && bit_ok;
    endsequence
    sequence s_load_tmr;
        instr_valid && op == lce_pkg::LCE_OP_LOAD_TIMER_STATUS && tc_ok;
    endsequence
    sequence s_load_inv_tmr;
        instr_valid && op == lce_pkg::LCE_OP_LOAD_INVERTED_TIMER_STATUS && tc_ok;
    endsequence
    sequence s_load_cnt;
        instr_valid && op == lce_pkg::LCE_OP_LOAD_COUNTER_STATUS && tc_ok;
    endsequence
    sequence s_load_inv_cnt;
        instr_valid && op == lce_pkg::LCE_OP_LOAD_INVERTED_COUNTER_STATUS && tc_ok;
    endsequence
    AST_LOAD_THEN_OR: assert property (@(posedge sys_clk) disable iff (reset) // [RULE_03]
        s_load_bit ##1 s_or_bit
        |=> rung_result == ($past(bit_value, 2) | $past(bit_value)))
        else $error("load then parallel contact wrong");
    AST_INV_THEN_OR: assert property (@(posedge sys_clk) disable iff (reset) // [RULE_03]
        s_load_inv_bit ##1 s_or_bit
        |=> rung_result == (!$past(bit_value, 2) | $past(bit_value)))
        else $error("inverted load then parallel contact wrong");
    AST_TMR_THEN_OR: assert property (@(posedge sys_clk) disable iff (reset) // [RULE_03]
        s_load_tmr ##1 s_or_bit
        |=> rung_result == (($past(timer_current, 2) >= $past(timer_preset, 2))
        | $past(bit_value)))
        else $error("timer load then parallel contact wrong");
    AST_INV_TMR_THEN_OR: assert property (@(posedge sys_clk) disable iff (reset) // [RULE_05]
        s_load_inv_tmr ##1 s_or_bit
        |=> rung_result == (($past(timer_current, 2) < $past(timer_preset, 2))
        | $past(bit_value)))
        else $error("inverted timer load then parallel contact wrong");
    AST_CNT_THEN_OR: assert property (@(posedge sys_clk) disable iff (reset) // [RULE_03]
        s_load_cnt ##1 s_or_bit
        |=> rung_result == (($past(counter_current, 2) >= $past(counter_preset, 2))
        | $past(bit_value)))
        else $error("counter load then parallel contact wrong");
    AST_INV_CNT_THEN_OR: assert property (@(posedge sys_clk) disable iff (reset) // [RULE_07]
        s_load_inv_cnt ##1 s_or_bit
        |=> rung_result == (($past(counter_current, 2) < $past(counter_preset, 2))
        | $past(bit_value)))
        else $error("inverted counter load then parallel contact wrong");
endmodule

// [rtl/lce_pkg.sv]
// Package: opcodes, operand ranges and result states of the contact evaluator
package lce_pkg;
    // Instruction opcodes
    typedef enum logic [3:0] {
        LCE_OP_NOP = 4'h0,
        LCE_OP_LOAD_CONTACT = 4'h1,
        LCE_OP_LOAD_INVERTED_CONTACT = 4'h2,
        LCE_OP_OR_CONTACT = 4'h3,
        LCE_OP_LOAD_TIMER_STATUS = 4'h4,
        LCE_OP_LOAD_INVERTED_TIMER_STATUS = 4'h5,
        LCE_OP_LOAD_COUNTER_STATUS = 4'h6,
        LCE_OP_LOAD_INVERTED_COUNTER_STATUS = 4'h7
    } lce_op_t;

    // Operand width: octal address up to 1077 needs 10 bits
    localparam int LCE_ADDR_W = 10;
    localparam int LCE_VAL_W = 16;
    // Contact ranges, written octal
    localparam logic [9:0] LCE_IO_LO = 10'o000;
    localparam logic [9:0] LCE_IO_HI = 10'o177;
    localparam logic [9:0] LCE_IO2_LO = 10'o700;
    localparam logic [9:0] LCE_IO2_HI = 10'o767;
    localparam logic [9:0] LCE_CR_LO = 10'o160;
    localparam logic [9:0] LCE_CR_HI = 10'o373;
    localparam logic [9:0] LCE_CR2_LO = 10'o1000;
    localparam logic [9:0] LCE_CR2_HI = 10'o1067;
    localparam logic [9:0] LCE_SP_LO = 10'o374;
    localparam logic [9:0] LCE_SP_HI = 10'o377;
    localparam logic [9:0] LCE_SP2_LO = 10'o770;
    localparam logic [9:0] LCE_SP2_HI = 10'o777;
    localparam logic [9:0] LCE_SP3_LO = 10'o1074;
    localparam logic [9:0] LCE_SP3_HI = 10'o1077;
    localparam logic [9:0] LCE_SR_LO = 10'o400;
    localparam logic [9:0] LCE_SR_HI = 10'o577;
    // Timer and counter range
    localparam logic [9:0] LCE_TC_LO = 10'o600;
    localparam logic [9:0] LCE_TC_HI = 10'o677;
    localparam int LCE_TC_N = 64;
    localparam logic [5:0] LCE_TC_IDX_W6 = 6'h3f;
    // Result reset value
    localparam logic LCE_RESULT_RST = 1'b0;
endpackage

// [verif/test_ladder_contact_evaluator.sv]
// Self-checking bench for the ladder contact evaluator
`timescale 1ns/100ps
module test_ladder_contact_evaluator;
    logic sys_clk = 1'h0;
    logic reset = 1'h1;
    logic instr_valid = 1'h0;
    logic [3:0] instr_op = 4'h0;
    logic [9:0] instr_addr = 10'h000;
    logic bit_value = 1'h0;
    logic [15:0] timer_current = 16'h0000;
    logic [15:0] timer_preset = 16'h0000;
    logic [15:0] counter_current = 16'h0000;
    logic [15:0] counter_preset = 16'h0000;
    logic [9:0] bit_addr;
    logic [5:0] tc_index;
    logic rung_result;
    logic result_valid;
    logic addr_error;
    int error_cnt = 0;
    int checks_done = 0;

    always #50 sys_clk = ~sys_clk;

    lce_ladder_contact_evaluator lce_ladder_contact_evaluator_inst
    (
        .sys_clk(sys_clk), .reset(reset), .instr_valid(instr_valid),
        .instr_op(instr_op), .instr_addr(instr_addr), .bit_addr(bit_addr),
        .bit_value(bit_value), .tc_index(tc_index), .timer_current(timer_current),
        .timer_preset(timer_preset), .counter_current(counter_current),
        .counter_preset(counter_preset), .rung_result(rung_result),
        .result_valid(result_valid), .addr_error(addr_error)
    );

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Preset 8000 with current one below catches a signed compare
    task automatic run(input logic [3:0] op, input logic [9:0] addr,
        input logic bv, tge, cge, exp_res, exp_err);
        @(posedge sys_clk);
        instr_valid <= 1'h1;
        instr_op <= op;
        instr_addr <= addr;
        bit_value <= bv;
        timer_current <= tge ? 16'h8000 : 16'h7fff;
        timer_preset <= 16'h8000;
        counter_current <= cge ? 16'h8000 : 16'h7fff;
        counter_preset <= 16'h8000;
        @(posedge sys_clk);
        instr_valid <= 1'h0;
        #1;
        check("bit_addr", 16'(bit_addr), 16'(addr));
        check("tc_index", 16'(tc_index), 16'(6'(addr - 10'o600)));
        check("rung_result", 16'(rung_result), 16'(exp_res));
        check("result_valid", 16'(result_valid), 16'(!exp_err));
        check("addr_error", 16'(addr_error), 16'(exp_err));
    endtask

    task automatic t_loads;
        run(4'h1, 10'o000, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0);
        run(4'h1, 10'o1067, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0);
        run(4'h2, 10'o777, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0);
        run(4'h2, 10'o400, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0);
    endtask

    task automatic t_parallel;
        run(4'h3, 10'o001, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0);
        run(4'h3, 10'o767, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0);
        run(4'h2, 10'o373, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
        run(4'h3, 10'o1074, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0);
    endtask

    // Timer and counter always disagree, so a swapped source shows
    task automatic t_status;
        run(4'h4, 10'o600, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0);
        run(4'h4, 10'o677, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0);
        run(4'h5, 10'o611, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0);
        run(4'h5, 10'o620, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0);
        run(4'h6, 10'o602, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0);
        run(4'h6, 10'o677, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0);
        run(4'h7, 10'o610, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0);
        run(4'h7, 10'o600, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0);
    endtask

    task automatic t_refused;
        run(4'h1, 10'o600, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1);
        run(4'h2, 10'o374, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0);
        run(4'h3, 10'o1070, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1);
        run(4'h4, 10'o577, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1);
        run(4'h0, 10'o000, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1);
        run(4'h8, 10'o000, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1);
        run(4'h1, 10'o1100, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1);
        run(4'h6, 10'o700, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1);
        run(4'h7, 10'o577, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1);
        run(4'h5, 10'o1000, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1);
        run(4'hf, 10'o000, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1);
    endtask

    // Drives one instruction with no idle cycle after the previous one
    task automatic drive(input logic [3:0] op, input logic [9:0] addr,
        input logic bv, tge, cge);
        @(posedge sys_clk);
        instr_valid <= 1'h1;
        instr_op <= op;
        instr_addr <= addr;
        bit_value <= bv;
        timer_current <= tge ? 16'h8000 : 16'h7fff;
        timer_preset <= 16'h8000;
        counter_current <= cge ? 16'h8000 : 16'h7fff;
        counter_preset <= 16'h8000;
    endtask

    task automatic expect_res(input logic exp_res);
        #1;
        check("rung_result", 16'(rung_result), 16'(exp_res));
        check("result_valid", 16'(result_valid), 16'h0001);
        check("addr_error", 16'(addr_error), 16'h0000);
    endtask

    // Each check sees the instruction taken at the edge just passed
    task automatic t_back_to_back;
        drive(4'h2, 10'o010, 1'h1, 1'h0, 1'h0);
        drive(4'h3, 10'o011, 1'h1, 1'h0, 1'h0);
        expect_res(1'h0);
        drive(4'h4, 10'o600, 1'h0, 1'h0, 1'h1);
        expect_res(1'h1);
        drive(4'h3, 10'o012, 1'h0, 1'h0, 1'h0);
        expect_res(1'h0);
        drive(4'h6, 10'o677, 1'h0, 1'h1, 1'h1);
        expect_res(1'h0);
        drive(4'h3, 10'o013, 1'h0, 1'h0, 1'h0);
        expect_res(1'h1);
        drive(4'h1, 10'o020, 1'h0, 1'h0, 1'h0);
        expect_res(1'h1);
        drive(4'h3, 10'o021, 1'h1, 1'h0, 1'h0);
        expect_res(1'h0);
        drive(4'h5, 10'o601, 1'h0, 1'h1, 1'h0);
        expect_res(1'h1);
        drive(4'h3, 10'o022, 1'h0, 1'h0, 1'h0);
        expect_res(1'h0);
        drive(4'h7, 10'o602, 1'h0, 1'h1, 1'h0);
        expect_res(1'h0);
        drive(4'h3, 10'o023, 1'h0, 1'h0, 1'h0);
        expect_res(1'h1);
        @(posedge sys_clk);
        instr_valid <= 1'h0;
        expect_res(1'h1);
    endtask

    // Reset in mid-run clears the result without waiting for a clock
    task automatic t_reset;
        run(4'h1, 10'o002, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0);
        @(posedge sys_clk);
        reset <= 1'h1;
        #1;
        check("rung_result", 16'(rung_result), 16'h0000);
        check("result_valid", 16'(result_valid), 16'h0000);
        check("addr_error", 16'(addr_error), 16'h0000);
        @(posedge sys_clk);
        reset <= 1'h0;
        run(4'h2, 10'o003, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0);
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        repeat (8) @(posedge sys_clk);
        #1;
        check("rung_result", 16'(rung_result), 16'h0000);
        check("result_valid", 16'(result_valid), 16'h0000);
        @(posedge sys_clk);
        reset <= 1'h0;
        t_loads;
        t_parallel;
        t_status;
        t_refused;
        t_back_to_back;
        t_reset;
        final_report;
    end
endmodule
